// [core/arith_instr_decode_timing.sv]
// Arithmetic group decoder with per-form execution clock counts
`timescale 1ns/10ps
module arith_instr_decode_timing
    import arith_decode_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       fetch_valid,
    input  wire logic [7:0] fetch_byte,
    output logic            fetch_ready,
    output logic            dec_valid,
    output decoded_t        dec_info,
    output logic            exec_busy,
    output logic            exec_done
);
    typedef enum {S_OP, S_MODRM, S_SECOND, S_EXTRA, S_RUN} state_t;

    state_t     state;
    state_t     next_state;
    logic [7:0] opcode;
    logic [2:0] extra_left;
    decoded_t   next_info;
    // Decode under way; dec_info changes only at issue
    decoded_t   pend;
    logic       next_issue;
    logic [2:0] next_extra;

    function automatic logic [4:0] pick(input logic w, input logic m, input logic [4:0] rb,
                                        input logic [4:0] rw, input logic [4:0] mb,
                                        input logic [4:0] mw);
        if (m) return w ? mw : mb;
        return w ? rw : rb;
    endfunction : pick

    function automatic logic [1:0] disp_len(input logic [7:0] modrm);
        if (modrm[7:6] == 2'h1) return 2'h1;
        if (modrm[7:6] == 2'h2) return 2'h2;
        if (modrm[7:6] == 2'h0 && modrm[2:0] == RM_DIRECT) return 2'h2;
        return 2'h0;
    endfunction : disp_len

    wire        take      = fetch_valid && fetch_ready;
    wire        op_w      = fetch_byte[0];
    wire        st_w      = opcode[0];
    wire        mem       = fetch_byte[7:6] != MOD_REG;
    wire [2:0]  sub       = fetch_byte[5:3];
    wire        is_grp3   = (opcode & 8'hfe) == OPC_GRP3;
    wire        is_grp45  = (opcode & 8'hfe) == OPC_GRP45;
    wire        is_mulimm = (opcode & 8'hfd) == OPC_PROD_IMM;
    wire        is_cmprm  = (opcode & 8'hfe) == OPC_COMP_RM_REG
                         || (opcode & 8'hfe) == OPC_COMP_REG_RM;
    wire        is_immgrp = (opcode & 8'hfc) == OPC_IMM_GRP;
    // Immediate length: sw=01 gives a full word, otherwise one byte
    wire [1:0]  imm_grp   = (opcode[1:0] == 2'h1) ? 2'h2 : 2'h1;
    // second immediate byte only when s is 0
    wire [1:0]  imm_prod  = opcode[1] ? 2'h1 : 2'h2;

    always_comb begin
        next_state = state;
        next_info  = pend;
        next_issue = 1'b0;
        next_extra = extra_left;
        case (state)
            S_OP: begin
                if (take) begin
                    next_info = '{OP_ILLEGAL, op_w, 1'b0, 2'h0, 2'h0, CLK_ONE};
                    next_state = S_RUN;
                    next_issue = 1'b1;
                    case (fetch_byte)
                        OPC_ASC_SUB: next_info = '{ascii_fix_after_subtract, 1'b0, 1'b0, 2'h0,
                                               2'h0, CLK_THREE};
                        OPC_ASC_ADD: next_info = '{ascii_fix_after_add, 1'b0, 1'b0, 2'h0, 2'h0,
                                               CLK_THREE};
                        OPC_BCD_SUB: next_info = '{bcd_fix_after_subtract, 1'b0, 1'b0, 2'h0,
                                               2'h0, CLK_TWO};
                        OPC_BCD_ADD: next_info = '{bcd_fix_after_add, 1'b0, 1'b0, 2'h0, 2'h0,
                                               CLK_TWO};
                        OPC_EXT_BYTE: next_info = '{byte_to_word_extend, 1'b1, 1'b0, 2'h0, 2'h0,
                                               CLK_TWO};
                        OPC_EXT_WORD: next_info = '{word_to_double_extend, 1'b1, 1'b0, 2'h0,
                                               2'h0, CLK_TWO};
                        OPC_ASC_DIVIDE, OPC_ASC_PROD: begin
                            next_state = S_SECOND;
                            next_issue = 1'b0;
                        end
                        default: begin
                            if ((fetch_byte & 8'hf8) == OPC_DECR_REG) begin
                                next_info = '{decrement_op, 1'b1, 1'b0, 2'h0, 2'h0, CLK_ONE};
                            end else if ((fetch_byte & 8'hfe) == OPC_COMP_ACC) begin
                                next_info = '{compare_op, op_w, 1'b0, 2'h0,
                                              op_w ? 2'h2 : 2'h1, CLK_ONE};
                                next_extra = op_w ? 3'h2 : 3'h1;
                                next_state = S_EXTRA;
                                next_issue = 1'b0;
                            end else if ((fetch_byte & 8'hfe) == OPC_GRP3
                                      || (fetch_byte & 8'hfe) == OPC_GRP45
                                      || (fetch_byte & 8'hfd) == OPC_PROD_IMM
                                      || (fetch_byte & 8'hfe) == OPC_COMP_RM_REG
                                      || (fetch_byte & 8'hfe) == OPC_COMP_REG_RM
                                      || (fetch_byte & 8'hfc) == OPC_IMM_GRP) begin
                                next_state = S_MODRM;
                                next_issue = 1'b0;
                            end
                        end
                    endcase
                end
            end
            S_SECOND: begin
                if (take) begin
                    if (fetch_byte != OPC_BASE_TEN)
                        next_info = '{OP_ILLEGAL, 1'b0, 1'b0, 2'h0, 2'h0, CLK_ONE};
                    else if (opcode == OPC_ASC_DIVIDE)
                        next_info = '{ascii_fix_before_divide, 1'b0, 1'b0, 2'h0, 2'h0,
                                      CLK_ASC_DIVIDE};
                    else
                        next_info = '{ascii_fix_after_multiply, 1'b0, 1'b0, 2'h0, 2'h0,
                                      CLK_ASC_PROD};
                    next_state = S_RUN;
                    next_issue = 1'b1;
                end
            end
            S_MODRM: begin
                if (take) begin
                    next_info = '{OP_ILLEGAL, st_w, mem, disp_len(fetch_byte), 2'h0, CLK_ONE};
                    if (is_grp3) begin
                        case (sub)
                            SUB_NEGATE: begin
                                next_info.op     = sign_change_op;
                                next_info.clocks = mem ? CLK_RM_MEM : CLK_ONE;
                            end
                            SUB_UPROD: begin
                                next_info.op     = unsigned_product;
                                next_info.clocks = pick(st_w, mem, CLK_UPROD_RB, CLK_UPROD_RW,
                                                        CLK_UPROD_MB, CLK_UPROD_MW);
                            end
                            SUB_SPROD: begin
                                next_info.op     = signed_multiply;
                                next_info.clocks = pick(st_w, mem, CLK_SPROD_RB, CLK_SPROD_RW,
                                                        CLK_SPROD_MB, CLK_SPROD_MW);
                            end
                            SUB_DIV: begin
                                next_info.op     = unsigned_divide;
                                next_info.clocks = pick(st_w, mem, CLK_DIV_RB, CLK_DIV_RW,
                                                        CLK_DIV_MB, CLK_DIV_MW);
                            end
                            SUB_SDIV: begin
                                next_info.op     = signed_divide;
                                next_info.clocks = pick(st_w, mem, CLK_DIV_RB, CLK_DIV_RW,
                                                        CLK_DIV_MB, CLK_DIV_MW);
                            end
                            default: next_info.op = OP_ILLEGAL;
                        endcase
                    end else if (is_grp45 && sub == SUB_DECR) begin
                        next_info.op     = decrement_op;
                        next_info.clocks = mem ? CLK_RM_MEM : CLK_ONE;
                    end else if (is_mulimm) begin
                        next_info.op        = signed_multiply_imm;
                        next_info.word      = 1'b1;
                        next_info.imm_bytes = imm_prod;
                        next_info.clocks    = mem ? CLK_SPROD_IMM_M : CLK_SPROD_IMM_R;
                    end else if (is_cmprm || (is_immgrp && sub == SUB_COMPARE)) begin
                        next_info.op        = compare_op;
                        next_info.imm_bytes = is_immgrp ? imm_grp : 2'h0;
                        next_info.clocks    = mem ? CLK_COMP_MEM : CLK_ONE;
                    end
                    // Illegal forms consume no further bytes
                    if (next_info.op == OP_ILLEGAL) begin
                        next_info.disp_bytes = 2'h0;
                        next_info.imm_bytes  = 2'h0;
                    end
                    next_extra = {1'b0, next_info.disp_bytes} + {1'b0, next_info.imm_bytes};
                    if (next_extra == 3'h0) begin
                        next_state = S_RUN;
                        next_issue = 1'b1;
                    end else begin
                        next_state = S_EXTRA;
                    end
                end
            end
            S_EXTRA: begin
                if (take) begin
                    next_extra = extra_left - 3'h1;
                    if (extra_left == 3'h1) begin
                        next_state = S_RUN;
                        next_issue = 1'b1;
                    end
                end
            end
            S_RUN: begin
                // Return only after execution ends; no overlap with next fetch
                if (exec_done)
                    next_state = S_OP;
            end
            default: next_state = S_OP;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state       <= S_OP;
            opcode      <= 8'h00;
            extra_left  <= 3'h0;
            dec_info    <= DECODED_RESET;
            pend        <= DECODED_RESET;
            dec_valid   <= 1'b0;
            fetch_ready <= 1'b0;
        end else begin
            state       <= next_state;
            if (take && state == S_OP)
                opcode  <= fetch_byte;
            extra_left  <= next_extra;
            pend        <= next_info;
            if (next_issue)
                dec_info <= next_info;
            dec_valid   <= next_issue;
            fetch_ready <= (next_state != S_RUN);
        end
    end

    exec_timer u_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .start    (dec_valid),
        .count    (dec_info.clocks),
        .busy     (exec_busy),
        .done     (exec_done)
    );
endmodule : arith_instr_decode_timing

// [core/arith_decode_pkg.sv]
// Opcode patterns, clock counts and decode types for the arithmetic decoder
package arith_decode_pkg;

    // Opcode patterns
    localparam logic [7:0] OPC_GRP3        = 8'hf6;  // 1111011w, w masked
    localparam logic [7:0] OPC_GRP45       = 8'hfe;  // 1111111w, w masked
    localparam logic [7:0] OPC_PROD_IMM    = 8'h69;  // 011010s1, s masked
    localparam logic [7:0] OPC_COMP_RM_REG = 8'h3a;  // 0011101w, w masked
    localparam logic [7:0] OPC_COMP_REG_RM = 8'h38;  // 0011100w, w masked
    localparam logic [7:0] OPC_IMM_GRP     = 8'h80;  // 100000sw, s and w masked
    localparam logic [7:0] OPC_COMP_ACC    = 8'h3c;  // 0011110w, w masked
    localparam logic [7:0] OPC_DECR_REG    = 8'h48;  // 01001reg, reg masked
    localparam logic [7:0] OPC_ASC_SUB     = 8'h3f;
    localparam logic [7:0] OPC_BCD_SUB     = 8'h2f;
    localparam logic [7:0] OPC_ASC_ADD     = 8'h37;
    localparam logic [7:0] OPC_BCD_ADD     = 8'h27;
    localparam logic [7:0] OPC_ASC_DIVIDE  = 8'hd5;
    localparam logic [7:0] OPC_ASC_PROD    = 8'hd4;
    localparam logic [7:0] OPC_BASE_TEN    = 8'h0a;
    localparam logic [7:0] OPC_EXT_BYTE    = 8'h98;
    localparam logic [7:0] OPC_EXT_WORD    = 8'h99;

    // Sub-op, mod and r/m field values in the mod/reg/r-m byte
    localparam logic [2:0] SUB_DECR        = 3'h1;
    localparam logic [2:0] SUB_NEGATE      = 3'h3;
    localparam logic [2:0] SUB_UPROD       = 3'h4;
    localparam logic [2:0] SUB_SPROD       = 3'h5;
    localparam logic [2:0] SUB_DIV         = 3'h6;
    localparam logic [2:0] SUB_SDIV        = 3'h7;
    localparam logic [2:0] SUB_COMPARE     = 3'h7;
    localparam logic [1:0] MOD_REG         = 2'h3;
    localparam logic [2:0] RM_DIRECT       = 3'h6;

    // Execution clock counts
    localparam logic [4:0] CLK_ONE         = 5'h01;
    localparam logic [4:0] CLK_TWO         = 5'h02;
    localparam logic [4:0] CLK_THREE       = 5'h03;
    localparam logic [4:0] CLK_RM_MEM      = 5'h08;
    localparam logic [4:0] CLK_COMP_MEM    = 5'h07;
    localparam logic [4:0] CLK_UPROD_RB    = 5'h0d;
    localparam logic [4:0] CLK_UPROD_RW    = 5'h15;
    localparam logic [4:0] CLK_UPROD_MB    = 5'h12;
    localparam logic [4:0] CLK_UPROD_MW    = 5'h1a;
    localparam logic [4:0] CLK_SPROD_RB    = 5'h10;
    localparam logic [4:0] CLK_SPROD_RW    = 5'h18;
    localparam logic [4:0] CLK_SPROD_MB    = 5'h18;
    localparam logic [4:0] CLK_SPROD_MW    = 5'h1d;
    localparam logic [4:0] CLK_SPROD_IMM_R = 5'h17;
    localparam logic [4:0] CLK_SPROD_IMM_M = 5'h1c;
    localparam logic [4:0] CLK_DIV_RB      = 5'h12;
    localparam logic [4:0] CLK_DIV_RW      = 5'h1a;
    localparam logic [4:0] CLK_DIV_MB      = 5'h17;
    localparam logic [4:0] CLK_DIV_MW      = 5'h1f;
    localparam logic [4:0] CLK_ASC_DIVIDE  = 5'h0e;
    localparam logic [4:0] CLK_ASC_PROD    = 5'h0f;

    // Eighteen kinds need five bits
    typedef enum logic [4:0] {
        OP_NONE, OP_ILLEGAL, decrement_op, sign_change_op, compare_op,
        unsigned_product, signed_multiply, signed_multiply_imm, unsigned_divide,
        signed_divide, ascii_fix_after_subtract, ascii_fix_after_add,
        ascii_fix_before_divide, ascii_fix_after_multiply, bcd_fix_after_subtract,
        bcd_fix_after_add, byte_to_word_extend, word_to_double_extend
    } op_kind_t;

    typedef struct packed {
        op_kind_t   op;
        logic       word;
        logic       mem;
        logic [1:0] disp_bytes;
        logic [1:0] imm_bytes;
        logic [4:0] clocks;
    } decoded_t;

    localparam decoded_t DECODED_RESET = '{OP_NONE, 1'b0, 1'b0, 2'h0, 2'h0, 5'h00};

endpackage : arith_decode_pkg

// [core/exec_timer.sv]
// Execution clock counter: busy for the loaded number of clocks
`timescale 1ns/10ps
module exec_timer
    import arith_decode_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic [4:0] count,
    output logic            busy,
    output logic            done
);
    logic [4:0] remaining;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            remaining <= 5'h00;
            busy      <= 1'b0;
            done      <= 1'b0;
        end else if (start) begin
            remaining <= count;
            busy      <= 1'b1;
            done      <= 1'b0;
        end else if (busy) begin
            remaining <= remaining - 5'h01;
            busy      <= (remaining > 5'h01);
            done      <= (remaining <= 5'h01);
        end else begin
            done      <= 1'b0;
        end
    end
endmodule : exec_timer

// [test/arith_timing_checker.sv]
// Port timing checker for the arithmetic decoder
`timescale 1ns/10ps
module arith_timing_checker
    import arith_decode_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       fetch_valid,
    input wire logic [7:0] fetch_byte,
    input wire logic       fetch_ready,
    input wire logic       dec_valid,
    input wire decoded_t   dec_info,
    input wire logic       exec_busy,
    input wire logic       exec_done
);
    logic [5:0] busy_cnt;
    logic [4:0] clk_lat;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Busy cycles since the last issue, compared at done
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            busy_cnt <= 6'h00;
            clk_lat  <= 5'h00;
        end else if (dec_valid) begin
            busy_cnt <= 6'h00;
            clk_lat  <= dec_info.clocks;
        end else if (exec_busy) begin
            busy_cnt <= busy_cnt + 6'h01;
        end
    end
    property p_issue_blocks; dec_valid |-> !fetch_ready; endproperty
    a_issue_blocks: assert property (p_issue_blocks) else $error("ready high at issue");
    property p_pulse; dec_valid |=> !dec_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("issue longer than one cycle");
    property p_start; dec_valid |=> exec_busy; endproperty
    a_start: assert property (p_start) else $error("timer did not start");
    property p_count; exec_done |-> busy_cnt == {1'b0, clk_lat}; endproperty
    a_count: assert property (p_count) else $error("busy length differs from count");
    property p_release; exec_done |=> fetch_ready && !exec_busy; endproperty
    a_release: assert property (p_release) else $error("no release after done");
    property p_hold; exec_busy |-> !fetch_ready; endproperty
    a_hold: assert property (p_hold) else $error("byte accepted while busy");
    property p_info; !dec_valid && $past(resetn) |-> $stable(dec_info); endproperty
    a_info: assert property (p_info) else $error("decode info changed without issue");
    property p_sprod;
        dec_valid && dec_info.op == signed_multiply && !dec_info.mem
            |-> dec_info.clocks == (dec_info.word ? 5'h18 : 5'h10);
    endproperty
    a_sprod: assert property (p_sprod) else $error("signed multiply count wrong");
    property p_imm;
        dec_valid && dec_info.op == signed_multiply_imm
            |-> dec_info.clocks == (dec_info.mem ? 5'h1c : 5'h17);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate multiply count wrong");
    property p_sdiv;
        dec_valid && dec_info.op == signed_divide |-> dec_info.clocks ==
            (dec_info.mem ? (dec_info.word ? 5'h1f : 5'h17) : (dec_info.word ? 5'h1a : 5'h12));
    endproperty
    a_sdiv: assert property (p_sdiv) else $error("signed divide count wrong");
    property p_adjust;
        dec_valid && dec_info.op inside {ascii_fix_after_subtract, ascii_fix_after_add}
            |-> dec_info.clocks == 5'h03;
    endproperty
    a_adjust: assert property (p_adjust) else $error("adjust count wrong");
    property p_extend;
        dec_valid && dec_info.op inside {byte_to_word_extend, word_to_double_extend}
            |-> dec_info.clocks == 5'h02;
    endproperty
    a_extend: assert property (p_extend) else $error("extend count wrong");
    c_sprod: cover property (dec_valid && dec_info.op == signed_multiply);
    c_sdiv: cover property (dec_valid && dec_info.op == signed_divide && dec_info.mem);
    c_bad: cover property (dec_valid && dec_info.op == OP_ILLEGAL);
endmodule : arith_timing_checker

bind arith_instr_decode_timing arith_timing_checker chk_u (.core_clk(core_clk),
    .resetn(resetn), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
    .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_info(dec_info),
    .exec_busy(exec_busy), .exec_done(exec_done));

// [test/arith_instr_decode_timing_bench.sv]
// Self-checking bench for the arithmetic decoder
`timescale 1ns/10ps
module arith_instr_decode_timing_bench;
    import arith_decode_pkg::*;
    logic       core_clk;
    logic       resetn;
    logic       fetch_valid;
    logic [7:0] fetch_byte;
    logic       fetch_ready;
    logic       dec_valid;
    decoded_t   dec_info;
    logic       exec_busy;
    logic       exec_done;
    int         err_count;
    int         checked;
    int         w;

    arith_instr_decode_timing dut_u (.core_clk(core_clk), .resetn(resetn),
        .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .fetch_ready(fetch_ready),
        .dec_valid(dec_valid), .dec_info(dec_info), .exec_busy(exec_busy),
        .exec_done(exec_done));

    always #12.5 core_clk = ~core_clk;

    task automatic report_and_stop;
        $display("Mismatches %0d, checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic give_up(input string what);
        err_count++;
        $display("[ERR] %s expected response seen timeout", what);
        report_and_stop();
    endtask : give_up

    // Offer one byte from a falling edge; waits counts refused cycles
    task automatic put(input logic [7:0] b, output int waits);
        waits = 0;
        fetch_valid = 1'b1;
        fetch_byte  = b;
        while (fetch_ready !== 1'b1) begin
            waits++;
            if (waits > 80) give_up("fetch_ready");
            @(negedge core_clk);
        end
        @(negedge core_clk);
    endtask : put

    task automatic issue(input op_kind_t op, input logic wd, input logic mm,
                         input logic chk, input logic [4:0] clocks);
        int n;
        int k;
        fetch_valid = 1'b0;
        n = 0;
        check("dec_valid", dec_valid, 1'b1);
        check("op", dec_info.op, op);
        check("clocks", dec_info.clocks, clocks);
        if (chk) check("word", dec_info.word, wd);
        if (chk) check("mem", dec_info.mem, mm);
        @(negedge core_clk);
        for (k = 0; k < 40 && exec_done !== 1'b1; k++) begin
            if (exec_busy === 1'b1) n++;
            @(negedge core_clk);
        end
        if (k == 40) give_up("exec_done");
        check("busy cycles", n, clocks);
        @(negedge core_clk);
        check("fetch_ready", fetch_ready, 1'b1);
    endtask : issue

    // Bytes are left aligned, first byte in the top lane
    task automatic run(input logic [31:0] b, input int n, input op_kind_t op,
                       input logic wd, input logic mm, input logic chk, input logic [4:0] clocks);
        for (int i = 0; i < n; i++) put(b[31-8*i -: 8], w);
        issue(op, wd, mm, chk, clocks);
        // Bytes after opcode and mod/reg/r-m byte
        if (chk && n > 1 && b[31:25] != 7'h1e)
            check("extra bytes", dec_info.disp_bytes + dec_info.imm_bytes, n - 2);
    endtask : run

    task automatic sc_sprod;
        run(32'hf6e80000, 2, signed_multiply, 1'b0, 1'b0, 1'b1, 5'h10);
        run(32'hf7e80000, 2, signed_multiply, 1'b1, 1'b0, 1'b1, 5'h18);
        run(32'hf72e3412, 4, signed_multiply, 1'b1, 1'b1, 1'b1, 5'h1d);
    endtask : sc_sprod

    task automatic sc_sprod_imm;
        run(32'h69c01122, 4, signed_multiply_imm, 1'b1, 1'b0, 1'b1, 5'h17);
        run(32'h6bc00500, 3, signed_multiply_imm, 1'b1, 1'b0, 1'b1, 5'h17);
        run(32'h6b46f005, 4, signed_multiply_imm, 1'b1, 1'b1, 1'b1, 5'h1c);
    endtask : sc_sprod_imm

    task automatic sc_sdiv;
        run(32'hf6f80000, 2, signed_divide, 1'b0, 1'b0, 1'b1, 5'h12);
        run(32'hf7f80000, 2, signed_divide, 1'b1, 1'b0, 1'b1, 5'h1a);
        run(32'hf63e3412, 4, signed_divide, 1'b0, 1'b1, 1'b1, 5'h17);
        run(32'hf77f1000, 3, signed_divide, 1'b1, 1'b1, 1'b1, 5'h1f);
    endtask : sc_sdiv

    task automatic sc_fixed;
        run(32'h3f000000, 1, ascii_fix_after_subtract, 1'b0, 1'b0, 1'b0, 5'h03);
        run(32'h37000000, 1, ascii_fix_after_add, 1'b0, 1'b0, 1'b0, 5'h03);
        run(32'hd50a0000, 2, ascii_fix_before_divide, 1'b0, 1'b0, 1'b0, 5'h0e);
        run(32'hd40a0000, 2, ascii_fix_after_multiply, 1'b0, 1'b0, 1'b0, 5'h0f);
        run(32'h98000000, 1, byte_to_word_extend, 1'b0, 1'b0, 1'b0, 5'h02);
        run(32'h99000000, 1, word_to_double_extend, 1'b0, 1'b0, 1'b0, 5'h02);
        run(32'hd50b0000, 2, OP_ILLEGAL, 1'b0, 1'b0, 1'b0, 5'h01);
    endtask : sc_fixed

    task automatic sc_other;
        run(32'hfec80000, 2, decrement_op, 1'b0, 1'b0, 1'b1, 5'h01);
        run(32'hff0e3412, 4, decrement_op, 1'b1, 1'b1, 1'b1, 5'h08);
        run(32'h48000000, 1, decrement_op, 1'b1, 1'b0, 1'b1, 5'h01);
        run(32'hf7d80000, 2, sign_change_op, 1'b1, 1'b0, 1'b1, 5'h01);
        run(32'h3ac00000, 2, compare_op, 1'b0, 1'b0, 1'b1, 5'h01);
        run(32'h3c050000, 2, compare_op, 1'b0, 1'b0, 1'b1, 5'h01);
        run(32'h83f81000, 3, compare_op, 1'b1, 1'b0, 1'b1, 5'h01);
        run(32'h81f83412, 4, compare_op, 1'b1, 1'b0, 1'b1, 5'h01);
        run(32'hf7e00000, 2, unsigned_product, 1'b1, 1'b0, 1'b1, 5'h15);
        run(32'hf6f00000, 2, unsigned_divide, 1'b0, 1'b0, 1'b1, 5'h12);
        run(32'h2f000000, 1, bcd_fix_after_subtract, 1'b0, 1'b0, 1'b0, 5'h02);
        run(32'h27000000, 1, bcd_fix_after_add, 1'b0, 1'b0, 1'b0, 5'h02);
    endtask : sc_other

    // byte held during execution is refused
    task automatic sc_refuse;
        put(8'h98, w);
        put(8'h3f, w);
        check("refused cycles", w, 32'h4);
        issue(ascii_fix_after_subtract, 1'b0, 1'b0, 1'b0, 5'h03);
    endtask : sc_refuse

    // reset in mid-execution clears the outputs
    task automatic sc_reset;
        put(8'hf7, w);
        put(8'he8, w);
        fetch_valid = 1'b0;
        repeat (3) @(negedge core_clk);
        resetn = 1'b0;
        repeat (2) @(negedge core_clk);
        check("busy in reset", exec_busy, 1'b0);
        check("ready in reset", fetch_ready, 1'b0);
        check("info in reset", dec_info, 32'h0);
        resetn = 1'b1;
        run(32'h98000000, 1, byte_to_word_extend, 1'b0, 1'b0, 1'b0, 5'h02);
    endtask : sc_reset

    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        fetch_valid = 1'b0;
        fetch_byte = 8'h00;
        err_count = 0;
        checked = 0;
        repeat (20) @(negedge core_clk);
        resetn = 1'b1;
        sc_sprod();
        sc_sprod_imm();
        sc_sdiv();
        sc_fixed();
        sc_other();
        sc_refuse();
        sc_reset();
        report_and_stop();
    end
endmodule : arith_instr_decode_timing_bench
